// ---- rtl/btc_bridge_ctl.sv ----
// Purpose: master time-out counters, discard/error reporting and chip control byte
// Assumes: config port, queue status and command-register bits are on core_clk
// Notes:   only the live-insertion pin crosses in from outside and is synchronised
`timescale 1ns/1ps
`default_nettype none

module btc_bridge_ctl
  import btc_pkg::*;
#(
  parameter int TO_LONG_CYCLES  = BTC_TO_LONG_CYCLES,
  parameter int TO_SHORT_CYCLES = BTC_TO_SHORT_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // configuration access
  input  wire logic        cfgWrite,
  input  wire logic        cfgRead,
  input  wire logic [7:0]  cfgDwordAddr,
  input  wire logic [3:0]  primaryCmdByteEnableLines_n,
  input  wire logic [31:0] cfgWrData,
  output var  logic [31:0] cfgRdData,
  output var  logic        cfgRdValid,
  // delayed transaction queues
  input  wire logic        priComplAtHead,
  input  wire logic        priRetrySeen,
  input  wire logic        secComplAtHead,
  input  wire logic        secRetrySeen,
  output var  logic        priDiscard,
  output var  logic        secDiscard,
  // system error, open drain
  input  wire logic        cmdSerrEnable,
  output var  logic        primarySystemErrorOut_n,
  output var  logic        primarySystemErrorOe_n,
  // command enables and live insertion
  input  wire logic        cmdIoEnable,
  input  wire logic        cmdMemEnable,
  input  wire logic        cmdMasterEnable,
  input  wire logic        insertPinIn,
  input  wire logic        insertPinInputOnly,
  output var  logic        effIoEnable,
  output var  logic        effMemEnable,
  output var  logic        effMasterEnable,
  output var  logic        acceptIoMem,
  output var  logic        secFastB2bEnable,
  // target memory write disconnect
  input  wire logic        wrQueueFull,
  input  wire logic        wrAt4kBoundary,
  input  wire logic        wrAtCacheLine,
  output var  logic        wrDisconnect,
  // upstream memory read handling
  input  wire logic [3:0]  upReadCmd,
  output var  logic        upPrefetch,
  output var  logic        upForwardByteEn,
  output var  logic        upDisconnectFirst
);

  typedef struct packed {
    logic                 ctlWrDisc;
    logic                 ctlPrefDis;
    logic                 ctlLiveIns;
    logic                 priSel;
    logic                 secSel;
    logic                 toStatus;
    logic                 toSerrEn;
    logic [BTC_CNT_W-1:0] priCnt;
    logic [BTC_CNT_W-1:0] secCnt;
    logic                 priRetried;
    logic                 secRetried;
    logic                 priDiscard;
    logic                 secDiscard;
    logic                 pinSync1;
    logic                 pinSync2;
    logic [31:0]          rdData;
    logic                 rdValid;
    logic                 serrOut_n;
    logic                 serrOe_n;
    logic                 ioEn;
    logic                 memEn;
    logic                 mstEn;
    logic                 accept;
    logic                 fastB2b;
    logic                 wrDisc;
    logic                 upPref;
    logic                 upFwdBe;
    logic                 upDiscFirst;
  } btc_state_t;

  typedef struct packed {
    logic                 discard;
    logic                 retried;
    logic [BTC_CNT_W-1:0] cnt;
  } btc_step_t;

  localparam logic [BTC_CNT_W-1:0] LONG_LAST  = BTC_CNT_W'(TO_LONG_CYCLES - 1);
  localparam logic [BTC_CNT_W-1:0] SHORT_LAST = BTC_CNT_W'(TO_SHORT_CYCLES - 1);

  btc_state_t st_r;
  btc_state_t st_nxt;

  // one clock of a master time-out counter, shared by both sides
  function automatic btc_step_t toStep(
    input logic                 atHead,
    input logic                 retry,
    input logic                 sel,
    input logic [BTC_CNT_W-1:0] cnt,
    input logic                 retried
  );
    btc_step_t s;
    logic [BTC_CNT_W-1:0] last;
    last = sel ? SHORT_LAST : LONG_LAST;
    s.discard = 1'b0;
    s.retried = retried;
    s.cnt     = cnt;
    if (!atHead) begin
      // idle until the completion reaches the queue head
      s.cnt     = '0;
      s.retried = 1'b0;
    end else if (retry) begin
      // a retry ends the wait for good
      s.cnt     = '0;
      s.retried = 1'b1;
    end else if (retried) begin
      s.cnt = '0;
    end else if (cnt == last) begin
      // expired with no retry yet
      s.discard = 1'b1;
      s.cnt     = '0;
      s.retried = 1'b1;
    end else begin
      s.cnt = cnt + 1'b1;
    end
    return s;
  endfunction

  // byte lane write strobe, byte enables active low
  function automatic logic laneWr(input logic [3:0] be_n, input int lane);
    return ~be_n[lane];
  endfunction

  always_comb begin
    btc_step_t priS;
    btc_step_t secS;
    logic      wrBc;
    logic      wrChip;
    logic      masked;
    logic      anyDiscard;
    logic      plainRead;
    st_nxt = st_r;
    wrBc   = cfgWrite && (cfgDwordAddr == BTC_OFS_BRIDGE_CTL);
    wrChip = cfgWrite && (cfgDwordAddr == BTC_OFS_CHIP_CTL);

    // counters
    priS = toStep(priComplAtHead, priRetrySeen, st_r.priSel, st_r.priCnt, st_r.priRetried);
    secS = toStep(secComplAtHead, secRetrySeen, st_r.secSel, st_r.secCnt,
                  st_r.secRetried);
    st_nxt.priCnt     = priS.cnt;
    st_nxt.priRetried = priS.retried;
    st_nxt.priDiscard = priS.discard;
    st_nxt.secCnt     = secS.cnt;
    st_nxt.secRetried = secS.retried;
    st_nxt.secDiscard = secS.discard;
    anyDiscard        = priS.discard || secS.discard;

    // register writes; only lanes with enable low take data
    if (wrBc && laneWr(primaryCmdByteEnableLines_n, BTC_LANE_BC_HI)) begin
      st_nxt.priSel   = cfgWrData[BTC_BIT_PRI_SEL];
      st_nxt.secSel   = cfgWrData[BTC_BIT_SEC_SEL];
      st_nxt.toSerrEn = cfgWrData[BTC_BIT_TO_SERR_EN];
      if (cfgWrData[BTC_BIT_TO_STATUS]) begin
        st_nxt.toStatus = 1'b0;
      end
    end
    if (wrChip && laneWr(primaryCmdByteEnableLines_n, BTC_LANE_CHIP)) begin
      st_nxt.ctlWrDisc  = cfgWrData[BTC_BIT_WR_DISC];
      st_nxt.ctlPrefDis = cfgWrData[BTC_BIT_PREF_DIS];
      st_nxt.ctlLiveIns = cfgWrData[BTC_BIT_LIVE_INS];
    end
    // a discard in the clearing cycle is not lost
    if (anyDiscard) begin
      st_nxt.toStatus = 1'b1;
    end

    // one-clock system error pulse on a time-out discard
    st_nxt.serrOut_n = 1'b0;
    st_nxt.serrOe_n  = ~(anyDiscard && st_r.toSerrEn && cmdSerrEnable);

    // reads; unlisted bits and dwords read zero
    st_nxt.rdValid = cfgRead;
    st_nxt.rdData  = '0;
    if (cfgRead) begin
      if (cfgDwordAddr == BTC_OFS_BRIDGE_CTL) begin
        st_nxt.rdData[BTC_BIT_FAST_B2B]   = 1'b0;
        st_nxt.rdData[BTC_BIT_PRI_SEL]    = st_r.priSel;
        st_nxt.rdData[BTC_BIT_SEC_SEL]    = st_r.secSel;
        st_nxt.rdData[BTC_BIT_TO_STATUS]  = st_r.toStatus;
        st_nxt.rdData[BTC_BIT_TO_SERR_EN] = st_r.toSerrEn;
      end else if (cfgDwordAddr == BTC_OFS_CHIP_CTL) begin
        st_nxt.rdData[BTC_BIT_WR_DISC]  = st_r.ctlWrDisc;
        st_nxt.rdData[BTC_BIT_PREF_DIS] = st_r.ctlPrefDis;
        st_nxt.rdData[BTC_BIT_LIVE_INS] = st_r.ctlLiveIns;
      end
    end

    // live insertion masking; first sync stage feeds only the second
    st_nxt.pinSync1 = insertPinIn;
    st_nxt.pinSync2 = st_r.pinSync1;
    masked = st_r.ctlLiveIns && insertPinInputOnly && st_r.pinSync2;
    st_nxt.ioEn   = cmdIoEnable && !masked;
    st_nxt.memEn  = cmdMemEnable && !masked;
    st_nxt.mstEn  = cmdMasterEnable && !masked;
    st_nxt.accept = (cmdIoEnable || cmdMemEnable) && !masked;

    st_nxt.fastB2b = 1'b0;

    // target write disconnect decision
    st_nxt.wrDisc = wrQueueFull || wrAt4kBoundary
                    || (st_r.ctlWrDisc && wrAtCacheLine);

    // upstream read handling
    plainRead = (upReadCmd == BTC_CMD_MEM_READ);
    if (!plainRead) begin
      // line and multiple reads keep prefetching
      st_nxt.upPref      = (upReadCmd == BTC_CMD_MEM_READ_LINE)
                           || (upReadCmd == BTC_CMD_MEM_READ_MULT);
      st_nxt.upFwdBe     = 1'b0;
      st_nxt.upDiscFirst = 1'b0;
    end else if (st_r.ctlPrefDis) begin
      st_nxt.upPref      = 1'b0;
      st_nxt.upFwdBe     = 1'b1;
      st_nxt.upDiscFirst = 1'b1;
    end else begin
      st_nxt.upPref      = 1'b1;
      st_nxt.upFwdBe     = 1'b0;
      st_nxt.upDiscFirst = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r            <= '0;
      st_r.ctlWrDisc  <= BTC_RST_CHIP_CTL[BTC_BIT_WR_DISC];
      st_r.ctlPrefDis <= BTC_RST_CHIP_CTL[BTC_BIT_PREF_DIS];
      st_r.ctlLiveIns <= BTC_RST_CHIP_CTL[BTC_BIT_LIVE_INS];
      st_r.priSel     <= BTC_RST_BIT;
      st_r.secSel     <= BTC_RST_BIT;
      st_r.toStatus   <= BTC_RST_BIT;
      st_r.toSerrEn   <= BTC_RST_BIT;
      st_r.serrOut_n  <= 1'b0;
      st_r.serrOe_n   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfgRdData               = st_r.rdData;
  assign cfgRdValid              = st_r.rdValid;
  assign priDiscard              = st_r.priDiscard;
  assign secDiscard              = st_r.secDiscard;
  assign primarySystemErrorOut_n = st_r.serrOut_n;
  assign primarySystemErrorOe_n  = st_r.serrOe_n;
  assign effIoEnable             = st_r.ioEn;
  assign effMemEnable            = st_r.memEn;
  assign effMasterEnable         = st_r.mstEn;
  assign acceptIoMem             = st_r.accept;
  assign secFastB2bEnable        = st_r.fastB2b;
  assign wrDisconnect            = st_r.wrDisc;
  assign upPrefetch              = st_r.upPref;
  assign upForwardByteEn         = st_r.upFwdBe;
  assign upDisconnectFirst       = st_r.upDiscFirst;

endmodule

`default_nettype wire

// ---- pkg/btc_pkg.sv ----
// Purpose: constants for the bridge time-out and chip control block
// Assumes: configuration dwords addressed by byte address, byte enables active low
// Notes:   time-out counts are in pci clocks, so no period conversion is needed
package btc_pkg;

  // configuration dword byte addresses
  localparam logic [7:0] BTC_OFS_BRIDGE_CTL = 8'h3C;
  localparam logic [7:0] BTC_OFS_CHIP_CTL   = 8'h40;

  // byte lanes inside a dword
  localparam int BTC_LANE_CHIP  = 0;
  localparam int BTC_LANE_BC_LO = 2;
  localparam int BTC_LANE_BC_HI = 3;

  // bridge control bits, as positions in the 0x3C dword
  localparam int BTC_BIT_FAST_B2B   = 23;
  localparam int BTC_BIT_PRI_SEL    = 24;
  localparam int BTC_BIT_SEC_SEL    = 25;
  localparam int BTC_BIT_TO_STATUS  = 26;
  localparam int BTC_BIT_TO_SERR_EN = 27;

  // chip control byte bits
  localparam int BTC_BIT_WR_DISC    = 1;
  localparam int BTC_BIT_PREF_DIS   = 4;
  localparam int BTC_BIT_LIVE_INS   = 5;

  // reset values
  localparam logic [7:0] BTC_RST_CHIP_CTL = 8'h00;
  localparam logic       BTC_RST_BIT      = 1'h0;

  // master time-out limits in pci clocks (select 0 / select 1)
  localparam int BTC_TO_LONG_CYCLES  = 32768;
  localparam int BTC_TO_SHORT_CYCLES = 1024;
  localparam int BTC_CNT_W           = 16;

  // upstream read command codes
  localparam logic [3:0] BTC_CMD_MEM_READ      = 4'h6;
  localparam logic [3:0] BTC_CMD_MEM_READ_MULT = 4'hC;
  localparam logic [3:0] BTC_CMD_MEM_READ_LINE = 4'hE;

endpackage

// ---- testbench/btc_bridge_ctl_sva.sv ----
// Purpose: port-level checks for btc_bridge_ctl
// Assumes: one clock domain, sync active-high rst
// Notes:   config bits are internal, so outputs are tied to input causes
`timescale 1ns/1ps
`default_nettype none
module btc_bridge_ctl_sva
  import btc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       cfgRead,
  input wire logic       cfgRdValid,
  input wire logic       priComplAtHead,
  input wire logic       priDiscard,
  input wire logic       secDiscard,
  input wire logic       cmdSerrEnable,
  input wire logic       primarySystemErrorOe_n,
  input wire logic       cmdIoEnable,
  input wire logic       effIoEnable,
  input wire logic       effMemEnable,
  input wire logic       acceptIoMem,
  input wire logic       secFastB2bEnable,
  input wire logic       wrQueueFull,
  input wire logic       wrAt4kBoundary,
  input wire logic       wrAtCacheLine,
  input wire logic       wrDisconnect,
  input wire logic [3:0] upReadCmd,
  input wire logic       upPrefetch
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_noFastB2b; !secFastB2bEnable; endproperty
  a_noFastB2b: assert property (p_noFastB2b)
    else $error("fast back-to-back enabled");
  property p_rdAnswer; cfgRead |=> cfgRdValid; endproperty
  a_rdAnswer: assert property (p_rdAnswer)
    else $error("read not answered");
  property p_serrCause; !primarySystemErrorOe_n |-> (priDiscard || secDiscard); endproperty
  a_serrCause: assert property (p_serrCause)
    else $error("system error without discard");
  property p_serrGate; !primarySystemErrorOe_n |-> $past(cmdSerrEnable); endproperty
  a_serrGate: assert property (p_serrGate)
    else $error("system error while command enable off");
  property p_discHead; priDiscard |-> $past(priComplAtHead); endproperty
  a_discHead: assert property (p_discHead)
    else $error("discard without head");
  property p_discOnce; priDiscard |=> !priDiscard; endproperty
  a_discOnce: assert property (p_discOnce)
    else $error("discard repeated");
  property p_wrFull; !$past(rst) && $past(wrQueueFull || wrAt4kBoundary) |-> wrDisconnect; endproperty
  a_wrFull: assert property (p_wrFull)
    else $error("no disconnect on full or 4k");
  property p_wrCause;
    wrDisconnect |-> $past(wrQueueFull || wrAt4kBoundary || wrAtCacheLine);
  endproperty
  a_wrCause: assert property (p_wrCause)
    else $error("disconnect without cause");
  property p_prefLine;
    !$past(rst) && ($past(upReadCmd) == BTC_CMD_MEM_READ_LINE ||
    $past(upReadCmd) == BTC_CMD_MEM_READ_MULT) |-> upPrefetch;
  endproperty
  a_prefLine: assert property (p_prefLine)
    else $error("line or multiple read not prefetched");
  property p_maskOnly; effIoEnable |-> $past(cmdIoEnable); endproperty
  a_maskOnly: assert property (p_maskOnly)
    else $error("io enable set without command bit");
  property p_accept; acceptIoMem == (effIoEnable || effMemEnable); endproperty
  a_accept: assert property (p_accept)
    else $error("accept differs from enables");
endmodule
bind btc_bridge_ctl btc_bridge_ctl_sva u_sva (.*);
`default_nettype wire

// ---- testbench/btc_queue_model.sv ----
// Purpose: delayed-transaction queue head and retrying initiator, one bus side
// Assumes: go and retryAt driven by the bench on the falling edge
// Notes:   head drops after retry or discard, as a queue that moves on
`timescale 1ns/1ps
`default_nettype none
module btc_queue_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [7:0] retryAt,
  input  wire logic       discard,
  output var  logic       head,
  output var  logic       retry
);
  logic [7:0] age_r;
  always_ff @(posedge core_clk) begin
    if (rst || discard || retry) begin
      head  <= 1'h0;
      retry <= 1'h0;
      age_r <= 8'h00;
    end else if (go || head) begin
      head  <= 1'h1;
      age_r <= age_r + 8'h01;
      retry <= head && retryAt != 8'h00 && age_r == retryAt;  // zero means never
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_bridge_timeout_chip_control.sv ----
// Purpose: register, time-out and chip control checks
// Assumes: short time-out parameters so the run stays brief
// Notes:   discard seen at falling edge limit+1 counted from the go edge
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_timeout_chip_control;
  import btc_pkg::*;
  localparam int LONG = 40;
  localparam int SHORT = 8;
  logic        core_clk, rst, cfgWrite, cfgRead, cfgRdValid, priGo, secGo;
  logic        priComplAtHead, priRetrySeen, secComplAtHead, secRetrySeen;
  logic        priDiscard, secDiscard, cmdSerrEnable, primarySystemErrorOut_n;
  logic        primarySystemErrorOe_n, cmdIoEnable, cmdMemEnable, cmdMasterEnable;
  logic        insertPinIn, insertPinInputOnly, effIoEnable, effMemEnable;
  logic        effMasterEnable, acceptIoMem, secFastB2bEnable, wrQueueFull;
  logic        wrAt4kBoundary, wrAtCacheLine, wrDisconnect, upPrefetch;
  logic        upForwardByteEn, upDisconnectFirst;
  logic [3:0]  primaryCmdByteEnableLines_n, upReadCmd;
  logic [7:0]  cfgDwordAddr, priAt, secAt;
  logic [31:0] cfgWrData, cfgRdData;
  int          num_errors, total_checks;
  btc_bridge_ctl #(.TO_LONG_CYCLES(LONG), .TO_SHORT_CYCLES(SHORT)) DUT (.*);
  btc_queue_model PRI (.core_clk, .rst, .go(priGo), .retryAt(priAt), .discard(priDiscard),
    .head(priComplAtHead), .retry(priRetrySeen));
  btc_queue_model SEC (.core_clk, .rst, .go(secGo), .retryAt(secAt), .discard(secDiscard),
    .head(secComplAtHead), .retry(secRetrySeen));
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge core_clk);
    {cfgWrite, cfgDwordAddr, primaryCmdByteEnableLines_n, cfgWrData} = {1'h1, a, be, d};
    @(negedge core_clk);
    cfgWrite = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge core_clk);
    {cfgRead, cfgDwordAddr} = {1'h1, a};
    @(negedge core_clk);
    // answer stands for one cycle only, so look before it goes
    ck({31'h0, cfgRdValid}, 32'h1);
    ck(cfgRdData, exp);
    cfgRead = 1'h0;
  endtask
  // fixed window doubles as the bound on the discard wait
  task automatic tmo(input logic s, input logic [7:0] at, input int expN, input logic expSerr);
    int n;
    logic serr;
    n = 0;
    serr = 1'h0;
    @(negedge core_clk);
    {priAt, secAt} = {at, at};
    if (s) secGo = 1'h1;
    else priGo = 1'h1;
    @(negedge core_clk);
    {priGo, secGo} = 2'h0;
    for (int i = 2; i < 60; i++) begin
      @(negedge core_clk);
      if ((s ? secDiscard : priDiscard) === 1'h1 && n == 0) n = i;
      if (primarySystemErrorOe_n === 1'h0) serr = 1'h1;
    end
    ck(n, expN);
    ck({31'h0, serr}, {31'h0, expSerr});
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {cfgWrite, cfgRead, cfgDwordAddr, primaryCmdByteEnableLines_n, cfgWrData} = '0;
    {priGo, secGo, priAt, secAt, insertPinIn, insertPinInputOnly} = '0;
    {wrQueueFull, wrAt4kBoundary, wrAtCacheLine, num_errors, total_checks} = '0;
    {cmdSerrEnable, cmdIoEnable, cmdMemEnable, cmdMasterEnable} = 4'hF;
    upReadCmd = BTC_CMD_MEM_READ;
    rst = 1'h1;
    repeat (10) @(negedge core_clk);
    rst = 1'h0;
    rd(BTC_OFS_CHIP_CTL, 32'h0);
    rd(BTC_OFS_BRIDGE_CTL, 32'h0);
    rd(8'h44, 32'h0);
    wr(BTC_OFS_CHIP_CTL, 4'hF, 32'hFFFF_FFFF);
    wr(BTC_OFS_CHIP_CTL, 4'h1, 32'hFFFF_FFFF);
    rd(BTC_OFS_CHIP_CTL, 32'h0);
    wr(BTC_OFS_CHIP_CTL, 4'hE, 32'hFFFF_FFFF);
    rd(BTC_OFS_CHIP_CTL, 32'h0000_0032);
    wr(BTC_OFS_BRIDGE_CTL, 4'h0, 32'hFDFF_FFFF);
    rd(BTC_OFS_BRIDGE_CTL, 32'h0900_0000);
    tmo(1'h0, 8'h00, SHORT + 1, 1'h1);
    rd(BTC_OFS_BRIDGE_CTL, 32'h0D00_0000);
    wr(BTC_OFS_BRIDGE_CTL, 4'h7, 32'h0D00_0000);
    rd(BTC_OFS_BRIDGE_CTL, 32'h0900_0000);
    cmdSerrEnable = 1'h0;
    tmo(1'h1, 8'h00, LONG + 1, 1'h0);
    tmo(1'h0, 8'h03, 0, 1'h0);
    wrAtCacheLine = 1'h1;
    for (int c = 0; c < 3; c++) begin
      upReadCmd = (c == 0) ? BTC_CMD_MEM_READ : (c == 1) ? BTC_CMD_MEM_READ_MULT
        : BTC_CMD_MEM_READ_LINE;
      @(negedge core_clk);
      ck({31'h0, upPrefetch}, (c == 0) ? 32'h0 : 32'h1);
    end
    upReadCmd = BTC_CMD_MEM_READ;
    {insertPinIn, insertPinInputOnly} = 2'h3;
    repeat (4) @(negedge core_clk);
    ck({wrDisconnect, upForwardByteEn, upDisconnectFirst}, 32'h7);
    ck({effIoEnable, effMemEnable, effMasterEnable, acceptIoMem}, 32'h0);
    wr(BTC_OFS_CHIP_CTL, 4'hE, 32'h0000_0000);
    repeat (2) @(negedge core_clk);
    ck({effIoEnable, effMemEnable, effMasterEnable, acceptIoMem}, 32'hF);
    ck({wrDisconnect, upPrefetch, upForwardByteEn}, 32'h2);
    wrAt4kBoundary = 1'h1;
    @(negedge core_clk);
    ck({31'h0, wrDisconnect}, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
